// File: include/scp_pkg.sv
// package for the system clock switch, prescaler and clock interrupt block
package scp_pkg;
  // register byte offsets
  localparam logic [7:0]  CFG_OFFSET    = 8'h00;
  localparam logic [7:0]  INT_OFFSET    = 8'h08;
  // clock configuration field positions
  localparam int          APB_LSB       = 8;
  localparam int          AHB_LSB       = 4;
  localparam int          STAT_LSB      = 2;
  localparam int          SEL_LSB       = 0;
  // clock interrupt field positions
  localparam int          FLAG_LSB      = 0;
  localparam int          STUCK_FLAG    = 7;
  localparam int          IEN_LSB       = 8;
  localparam int          CLR_LSB       = 16;
  localparam int          STUCK_CLR     = 23;
  localparam int          NUM_OSC       = 7;
  // reset values
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
  localparam logic [31:0] INT_RESET     = 32'h0000_0000;
  // switch latency
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          SWITCH_NS     = 400;
  localparam int          SWITCH_CYC    = (SWITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0]  SWITCH_CNT    = 4'(SWITCH_CYC);

  typedef enum logic [1:0] {
    SRC_RC   = 2'h0,
    SRC_XTAL = 2'h1,
    SRC_PLL  = 2'h2,
    SRC_RSVD = 2'h3
  } scp_src_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'h1,
    SW_WAIT = 2'h2
  } scp_sw_state_t;

  // oscillator status pins: bit 0 slow RC, 1 slow crystal, 2 rc 8mhz, 3 fast crystal, 4..6 plls
  typedef struct packed {
    logic               lp_exit;
    logic               crystal_stuck;
    logic               pll_from_crystal;
    logic [NUM_OSC-1:0] stable;
  } scp_pins_t;
endpackage

// File: hw/scp_clk_ctrl.sv
// system clock switch, bus prescalers and clock interrupt register with apb slave
// Operation
// - apb_low_prescaler bits 10:8; 0xx undivided, 100..111 divide main bus by 2,4,8,16.
// - main_bus_prescaler bits 7:4; 0xxx undivided, 1000..1111 divide by 2..16, 64..512.
// - sysclk_switch_status bits 3:2 shows active source; 00 rc, 01 crystal, 10 pll.
// - sysclk_source_select bits 1:0 written by software, same encoding as status.
// - on a software switch, status keeps old source until switch latency has passed.
// - leaving deep-sleep or standby forces source select to rc oscillator.
// - crystal failure while crystal feeds system clock forces rc oscillator.
// - writing 1 to bit 23 clears crystal_stuck_flag; 0 has no effect.
// - writing 1 to bit 22 clears third_pll_stable_flag.
// - writing 1 to bit 21 clears second_pll_stable_flag.
// - writing 1 to bit 20 clears main_pll_stable_flag.
// - writing 1 to bit 19 clears fast_crystal_stable_flag.
// - writing 1 to bit 18 clears rc_osc_stable_flag.
// - writing 1 to bit 17 clears slow_crystal_stable_flag.
// - whole interrupt register resets to zero.
// - stable flag sets when source turns stable with its enable set; sticky.
// - crystal_stuck_flag sets on crystal stuck detection; sticky until cleared.
module scp_clk_ctrl (
  input  wire logic             i_core_clk,  // system clock, 25 MHz
  input  wire logic             i_arst_n,    // async reset, active low
  input  wire logic             i_psel,      // apb select
  input  wire logic             i_penable,   // apb enable
  input  wire logic             i_pwrite,    // apb direction
  input  wire logic [7:0]       i_paddr,     // apb byte address
  input  wire logic [31:0]      i_pwdata,    // apb write data
  input  wire logic [3:0]       i_pstrb,     // apb byte strobes
  input  wire scp_pkg::scp_pins_t i_pins,    // asynchronous status pins
  output logic      [31:0]      o_prdata,    // apb read data
  output logic                  o_pready,    // apb ready
  output logic                  o_pslverr,   // apb error on unmapped address
  output logic      [1:0]       o_sys_src,   // active system clock source
  output logic                  o_ahb_en,    // main bus clock enable pulse
  output logic                  o_apb1_en,   // low peripheral bus clock enable pulse
  output logic                  o_irq        // clock interrupt request
);
  localparam int PW = $bits(scp_pkg::scp_pins_t);

  // pin synchronisers and filtered values
  logic [PW-1:0] sync1;
  logic [PW-1:0] sync2;
  logic [PW-1:0] sync3;
  logic [PW-1:0] pin_q;
  logic [PW-1:0] pin_prev;
  scp_pkg::scp_pins_t pin;
  scp_pkg::scp_pins_t pin_old;

  // configuration fields
  logic [2:0] apb_low_prescaler;
  logic [3:0] main_bus_prescaler;
  logic [1:0] sysclk_source_select;
  logic [1:0] sysclk_switch_status;
  scp_pkg::scp_sw_state_t sw_state;
  logic [3:0] sw_cnt;

  // interrupt register fields
  logic [scp_pkg::NUM_OSC-1:0] stable_irq_en;
  logic [scp_pkg::NUM_OSC-1:0] stable_flag;
  logic [scp_pkg::NUM_OSC-1:0] stable_en_prev;  // enables one cycle back, for the set edge
  logic                        crystal_stuck_flag;

  // prescaler counters
  logic [8:0] ahb_cnt;
  logic [3:0] apb_cnt;

  // bus decode
  logic        setup;
  logic        wr_acc;
  logic        hit_cfg;
  logic        hit_int;
  logic        force_rc;
  logic [31:0] cfg_word;
  logic [31:0] int_word;

  // number of halvings for the main bus prescaler code
  function automatic logic [3:0] ahb_shift(input logic [3:0] code);
    if (!code[3]) begin
      ahb_shift = 4'h0;
    end else if (!code[2]) begin
      ahb_shift = {2'h0, code[1:0]} + 4'h1;
    end else begin
      ahb_shift = {2'h0, code[1:0]} + 4'h6;
    end
  endfunction

  // number of halvings for the low peripheral prescaler code
  function automatic logic [3:0] apb_shift(input logic [2:0] code);
    apb_shift = code[2] ? ({2'h0, code[1:0]} + 4'h1) : 4'h0;
  endfunction

  // cycles between enable pulses, minus one
  function automatic logic [8:0] div_limit(input logic [3:0] sh);
    div_limit = 9'((10'h001 << sh) - 10'h001);
  endfunction

  assign pin     = pin_q;
  assign pin_old = pin_prev;
  assign setup   = i_psel && !i_penable;
  assign wr_acc  = i_psel && i_penable && i_pwrite && o_pready;
  assign hit_cfg = (i_paddr == scp_pkg::CFG_OFFSET);
  assign hit_int = (i_paddr == scp_pkg::INT_OFFSET);

  // crystal failure counts only when crystal feeds system clock directly or via pll
  assign force_rc = (pin.lp_exit && !pin_old.lp_exit)
                 || (pin.crystal_stuck && !pin_old.crystal_stuck
                     && ((sysclk_switch_status == scp_pkg::SRC_XTAL)
                      || (sysclk_switch_status == scp_pkg::SRC_PLL && pin.pll_from_crystal)));

  // three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= i_pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // filtered value changes once stages two and three agree, avoiding glitch counts
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_q    <= '0;
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_q;
      if (sync2 == sync3) begin
        pin_q <= sync3;
      end
    end
  end

  // prescaler fields and source select
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      apb_low_prescaler    <= scp_pkg::CFG_RESET[scp_pkg::APB_LSB +: 3];
      main_bus_prescaler   <= scp_pkg::CFG_RESET[scp_pkg::AHB_LSB +: 4];
      sysclk_source_select <= scp_pkg::CFG_RESET[scp_pkg::SEL_LSB +: 2];
    end else begin
      if (wr_acc && hit_cfg && i_pstrb[1]) begin
        apb_low_prescaler <= i_pwdata[scp_pkg::APB_LSB +: 3];
      end
      if (wr_acc && hit_cfg && i_pstrb[0]) begin
        main_bus_prescaler <= i_pwdata[scp_pkg::AHB_LSB +: 4];
      end
      // forced fallback beats a software write in the same cycle
      if (force_rc) begin
        sysclk_source_select <= scp_pkg::SRC_RC;
      end else if (wr_acc && hit_cfg && i_pstrb[0]) begin
        sysclk_source_select <= i_pwdata[scp_pkg::SEL_LSB +: 2];
      end
    end
  end

  // switch sequencer: status follows a software select after the switch latency
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sw_state             <= scp_pkg::SW_IDLE;
      sw_cnt               <= '0;
      sysclk_switch_status <= scp_pkg::CFG_RESET[scp_pkg::STAT_LSB +: 2];
    end else begin
      case (sw_state)
        scp_pkg::SW_IDLE: begin
          // a failed crystal cannot clock the handover, so fallback is immediate
          if (force_rc) begin
            sysclk_switch_status <= scp_pkg::SRC_RC;
          end else if (sysclk_source_select != sysclk_switch_status
                       && sysclk_source_select != scp_pkg::SRC_RSVD) begin
            sw_cnt   <= scp_pkg::SWITCH_CNT;
            sw_state <= scp_pkg::SW_WAIT;
          end
        end
        scp_pkg::SW_WAIT: begin
          if (force_rc) begin
            sysclk_switch_status <= scp_pkg::SRC_RC;
            sw_state             <= scp_pkg::SW_IDLE;
          end else if (sw_cnt == 4'h1) begin
            sysclk_switch_status <= sysclk_source_select;
            sw_state             <= scp_pkg::SW_IDLE;
          end else begin
            sw_cnt <= sw_cnt - 4'h1;
          end
        end
        default: begin
          sw_state <= scp_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // main bus enable divider, runs from the system clock
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ahb_cnt  <= '0;
      o_ahb_en <= 1'b0;
    end else begin
      if (ahb_cnt >= div_limit(ahb_shift(main_bus_prescaler))) begin
        ahb_cnt  <= '0;
        o_ahb_en <= 1'b1;
      end else begin
        ahb_cnt  <= ahb_cnt + 9'h001;
        o_ahb_en <= 1'b0;
      end
    end
  end

  // low peripheral enable counts main bus pulses
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      apb_cnt   <= '0;
      o_apb1_en <= 1'b0;
    end else begin
      o_apb1_en <= 1'b0;
      if (ahb_cnt >= div_limit(ahb_shift(main_bus_prescaler))) begin
        if ({5'h00, apb_cnt} >= div_limit(apb_shift(apb_low_prescaler))) begin
          apb_cnt   <= '0;
          o_apb1_en <= 1'b1;
        end else begin
          apb_cnt <= apb_cnt + 4'h1;
        end
      end
    end
  end

  // interrupt enables
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stable_irq_en <= scp_pkg::INT_RESET[scp_pkg::IEN_LSB +: scp_pkg::NUM_OSC];
    end else if (wr_acc && hit_int && i_pstrb[1]) begin
      stable_irq_en <= i_pwdata[scp_pkg::IEN_LSB +: scp_pkg::NUM_OSC];
    end
  end

  // sticky flags; a set in the same cycle as its clear wins
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stable_flag        <= scp_pkg::INT_RESET[scp_pkg::FLAG_LSB +: scp_pkg::NUM_OSC];
      crystal_stuck_flag <= scp_pkg::INT_RESET[scp_pkg::STUCK_FLAG];
      stable_en_prev     <= scp_pkg::INT_RESET[scp_pkg::IEN_LSB +: scp_pkg::NUM_OSC];
    end else begin
      // old enable kept so that enabling an already stable source still raises its flag
      stable_en_prev <= stable_irq_en;
      for (int i = 0; i < scp_pkg::NUM_OSC; i++) begin
        if (pin.stable[i] && stable_irq_en[i] && !(pin_old.stable[i] && stable_en_prev[i])) begin
          stable_flag[i] <= 1'b1;
        end else if (wr_acc && hit_int && i_pstrb[2] && i_pwdata[scp_pkg::CLR_LSB + i]) begin
          stable_flag[i] <= 1'b0;
        end
      end
      if (pin.crystal_stuck && !pin_old.crystal_stuck) begin
        crystal_stuck_flag <= 1'b1;
      end else if (wr_acc && hit_int && i_pstrb[2] && i_pwdata[scp_pkg::STUCK_CLR]) begin
        crystal_stuck_flag <= 1'b0;
      end
    end
  end

  // read words; clear bits and reserved bits read as zero
  always_comb begin
    cfg_word = '0;
    cfg_word[scp_pkg::APB_LSB +: 3]  = apb_low_prescaler;
    cfg_word[scp_pkg::AHB_LSB +: 4]  = main_bus_prescaler;
    cfg_word[scp_pkg::STAT_LSB +: 2] = sysclk_switch_status;
    cfg_word[scp_pkg::SEL_LSB +: 2]  = sysclk_source_select;
    int_word = '0;
    int_word[scp_pkg::IEN_LSB +: scp_pkg::NUM_OSC]  = stable_irq_en;
    int_word[scp_pkg::FLAG_LSB +: scp_pkg::NUM_OSC] = stable_flag;
    int_word[scp_pkg::STUCK_FLAG]                   = crystal_stuck_flag;
  end

  // apb answer registered in setup, so access phase completes with no wait state
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && !hit_cfg && !hit_int;
      if (setup && !i_pwrite) begin
        o_prdata <= hit_cfg ? cfg_word : (hit_int ? int_word : 32'h0000_0000);
      end else begin
        o_prdata <= '0;
      end
    end
  end

  // request and source outputs
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq     <= 1'b0;
      o_sys_src <= scp_pkg::SRC_RC;
    end else begin
      o_irq     <= (|stable_flag) || crystal_stuck_flag;
      o_sys_src <= sysclk_switch_status;
    end
  end
endmodule

// File: tb/scp_clk_ctrl_sva.sv
// assertions on the ports of the clock control block
module scp_clk_ctrl_sva (
  input wire logic               i_core_clk, // clock
  input wire logic               i_arst_n,   // reset
  input wire logic               i_psel,     // select
  input wire logic               i_penable,  // enable
  input wire logic               i_pwrite,   // write
  input wire logic [7:0]         i_paddr,    // address
  input wire logic [31:0]        i_pwdata,   // wdata
  input wire logic [3:0]         i_pstrb,    // strobes
  input wire scp_pkg::scp_pins_t i_pins,     // pins
  input wire logic [31:0]        o_prdata,   // rdata
  input wire logic               o_pready,   // ready
  input wire logic               o_pslverr,  // error
  input wire logic [1:0]         o_sys_src,  // source
  input wire logic               o_ahb_en,   // ahb tick
  input wire logic               o_apb1_en,  // apb tick
  input wire logic               o_irq       // irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic       acc;
  logic [3:0] since_cfg;
  // completed transfer; the counter ages config writes so early source changes show up
  assign acc = i_psel && i_penable && o_pready;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) since_cfg <= 4'hf;
    else if (acc && i_pwrite && i_paddr == 8'h00) since_cfg <= 4'h0;
    else if (since_cfg != 4'hf) since_cfg <= since_cfg + 4'h1;
  end
  property p_tick; o_apb1_en |-> o_ahb_en; endproperty
  a_tick: assert property (p_tick) else $error("apb tick alone");
  property p_rsvd; o_sys_src != 2'h3; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved source");
  property p_late; $changed(o_sys_src) && o_sys_src != 2'h0 |-> since_cfg >= 4'ha; endproperty
  a_late: assert property (p_late) else $error("switch too early");
  property p_wake; $rose(i_pins.lp_exit) |-> ##[1:8] o_sys_src == 2'h0; endproperty
  a_wake: assert property (p_wake) else $error("no wake fallback");
  property p_fail; $rose(i_pins.crystal_stuck) && o_sys_src == 2'h1 |-> ##[1:8] o_sys_src == 2'h0; endproperty
  a_fail: assert property (p_fail) else $error("no crystal fallback");
  property p_rst; $rose(i_arst_n) |-> !o_irq && o_sys_src == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_drop; $fell(o_irq) |-> $past(acc && i_pwrite && i_paddr == 8'h08, 2); endproperty
  a_drop: assert property (p_drop) else $error("irq fell alone");
  property p_wo; acc && !i_pwrite && i_paddr == 8'h08 |-> o_prdata[23:16] == 8'h00; endproperty
  a_wo: assert property (p_wo) else $error("clear bits read");
endmodule
bind scp_clk_ctrl scp_clk_ctrl_sva scp_clk_ctrl_sva_i (.i_core_clk, .i_arst_n, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .i_pins, .o_prdata, .o_pready, .o_pslverr, .o_sys_src,
  .o_ahb_en, .o_apb1_en, .o_irq);

// File: tb/scp_clk_ctrl_tb.sv
// self-checking bench for the clock control block
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %0t %s", $time, m); end end
module scp_clk_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata, rd;
  logic [3:0]         pstrb = 4'hf;
  logic               slv;
  scp_pkg::scp_pins_t pins = '0;
  logic               pready, pslverr, ahb_en, apb1_en, irq;
  logic [1:0]         sys_src;
  int                 err_total = 0, n_compared = 0;
  always #20 clk = ~clk;
  scp_clk_ctrl scp_clk_ctrl_i (.i_core_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .i_pins(pins),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_sys_src(sys_src),
    .o_ahb_en(ahb_en), .o_apb1_en(apb1_en), .o_irq(irq));
  task automatic end_sim();
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer, request held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    if (n >= 50) end_sim();
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // tick period between later pulses, so a divider change has settled first
  task automatic period(input logic s, input int e);
    int t[4];
    int k = 0;
    int n = 0;
    while (k < 4 && n < 3000) begin
      @(posedge clk);
      n++;
      if ((s ? apb1_en : ahb_en) === 1'b1) begin
        t[k] = n;
        k++;
      end
    end
    if (k < 4) err_total++;
    if (k < 4) end_sim();
    `CHK(t[3] - t[2], e, "tick period")
  endtask
  task automatic t_reset();
    apb(0, 8'h00, 0);
    `CHK(rd, scp_pkg::CFG_RESET, "cfg reset")
    apb(0, 8'h08, 0);
    `CHK(rd, 32'h0, "int reset")
  endtask
  // every divider code of both prescalers
  task automatic t_div();
    for (int c = 0; c < 16; c++) begin
      apb(1, 8'h00, 32'(c) << 4);
      period(0, c < 8 ? 1 : (c < 12 ? 2 << (c - 8) : 64 << (c - 12)));
    end
    for (int c = 0; c < 8; c++) begin
      apb(1, 8'h00, 32'(c) << 8);
      period(1, c < 4 ? 1 : 2 << (c - 4));
    end
  endtask
  // polls status until it shows the wanted source
  task automatic poll(input logic [1:0] s);
    int n = 0;
    do begin
      apb(0, 8'h00, 0);
      n++;
    end while (rd[3:2] !== s && n < 40);
    `CHK(rd[3:2], s, "switch status")
    `CHK(sys_src, s, "source out")
  endtask
  // software switch, reserved select, then both forced fallbacks
  task automatic t_switch();
    apb(1, 8'h00, 32'h1);
    apb(0, 8'h00, 0);
    `CHK(rd[3:0], 4'h1, "status early")
    poll(2'h1);
    apb(1, 8'h00, 32'h3);
    repeat (20) @(posedge clk);
    apb(0, 8'h00, 0);
    `CHK(rd[3:0], 4'h7, "reserved select")
    apb(1, 8'h00, 32'h2);
    poll(2'h2);
    pins.lp_exit <= 1'b1;
    repeat (8) @(posedge clk);
    apb(0, 8'h00, 0);
    `CHK(rd[3:0], 4'h0, "wake fallback")
    pins.lp_exit <= 1'b0;
    apb(1, 8'h00, 32'h1);
    poll(2'h1);
    pins.crystal_stuck <= 1'b1;
    repeat (8) @(posedge clk);
    apb(0, 8'h00, 0);
    `CHK(rd[3:0], 4'h0, "crystal fallback")
    apb(0, 8'h08, 0);
    `CHK({rd[7], irq}, 2'b11, "stuck flag")
    apb(1, 8'h08, 32'h0080_0000);
    pins.crystal_stuck <= 1'b0;
    apb(0, 8'h08, 0);
    `CHK({rd, irq}, 33'h0, "stuck cleared")
  endtask
  // stable flags: masked, then set, kept on a zero write, cleared by a one
  task automatic t_flags();
    pins.stable[3] <= 1'b1;
    repeat (8) @(posedge clk);
    apb(0, 8'h08, 0);
    `CHK(rd, 32'h0, "masked flag")
    pins.stable[3] <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      apb(1, 8'h08, 32'h0000_7f00);
      pins.stable[i] <= 1'b1;
      repeat (8) @(posedge clk);
      apb(1, 8'h08, 32'h0000_7f00);
      apb(0, 8'h08, 0);
      `CHK({rd, irq}, {32'h7f00 | (32'h1 << i), 1'b1}, "flag set")
      apb(1, 8'h08, 32'h7f00 | (32'h1 << (16 + i)));
      apb(0, 8'h08, 0);
      `CHK({rd, irq}, {32'h7f00, 1'b0}, "flag cleared")
    end
  endtask
  // byte strobes, unmapped addresses, enabling stable sources, then a reset in mid-run
  task automatic t_strobe();
    pstrb <= 4'h2;
    apb(1, 8'h00, 32'h0000_07f1);
    pstrb <= 4'h1;
    apb(1, 8'h00, 32'h0000_0080);
    pstrb <= 4'hf;
    apb(0, 8'h00, 0);
    `CHK(rd, 32'h0000_0780, "byte strobes")
    apb(1, 8'h0c, 32'h0000_0001);
    `CHK(slv, 1'b1, "unmapped write error")
    apb(0, 8'h00, 0);
    `CHK({slv, rd}, {1'b0, 32'h0000_0780}, "unmapped write ignored")
    apb(0, 8'h04, 0);
    `CHK({slv, rd}, {1'b1, 32'h0}, "unmapped read")
    apb(1, 8'h08, 32'h0);
    apb(1, 8'h08, 32'h0000_7f00);
    apb(0, 8'h08, 0);
    `CHK({rd, irq}, {32'h0000_7f7f, 1'b1}, "enable while stable")
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    apb(0, 8'h08, 0);
    `CHK({rd, irq}, 33'h0, "int after reset")
    apb(0, 8'h00, 0);
    `CHK({rd, sys_src}, 34'h0, "cfg after reset")
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_div();
    t_switch();
    t_flags();
    t_strobe();
    end_sim();
  end
endmodule
